//--- include/bcd_time_pkg.sv
// Purpose: Shared constants for the parallel BCD time output block.
// Assumes: 40 MHz system clock, 32-bit classic Wishbone register bus.
// Notes:   Timing counts are derived from the printed times and the clock rate.

package bcd_time_pkg;

  // ----------------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int MS_PERIOD_US = 1000;
  localparam int MS_CYCLES = MS_PERIOD_US * CLK_MHZ;
  localparam int KHZ_HIGH_US = 100;
  localparam int HZ_HIGH_MS = 900;
  localparam logic [3:0] HZ_LOW_DIGIT = 4'(HZ_HIGH_MS / 100);

  // ----------------------------------------------------------------------
  // Quality thresholds, in seconds of lost lock
  // ----------------------------------------------------------------------
  localparam int SEC_PER_MIN = 60;
  localparam int SEC_PER_HOUR = 3600;
  localparam int Q1MS_MIN = 8;
  localparam int Q5MS_MIN = 22;
  localparam int Q50MS_MIN = 92;
  localparam int Q500MS_HOUR = 22;
  localparam int ELAPSED_W = 17;
  localparam int Q1MS_SEC = Q1MS_MIN * SEC_PER_MIN;
  localparam int Q5MS_SEC = Q5MS_MIN * SEC_PER_MIN;
  localparam int Q50MS_SEC = Q50MS_MIN * SEC_PER_MIN;
  localparam int Q500MS_SEC = Q500MS_HOUR * SEC_PER_HOUR;

  // Quality line indices.
  localparam int QL_1MS = 0;
  localparam int QL_5MS = 1;
  localparam int QL_50MS = 2;
  localparam int QL_500MS = 3;

  // ----------------------------------------------------------------------
  // BCD limits
  // ----------------------------------------------------------------------
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [3:0] BCD_HALF = 4'h5;
  localparam logic [11:0] MS_MAX = 12'h999;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [11:0] DAY_MAX = 12'h365;
  localparam logic [11:0] DAY_MAX_LEAP = 12'h366;
  localparam logic [11:0] DAY_FIRST = 12'h001;

  // ----------------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TIME = 8'h04;
  localparam logic [7:0] REG_MSEC = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam int CTRL_DISP_ON = 0;
  localparam int CTRL_LEAP = 1;
  localparam int TIME_SEC_LSB = 0;
  localparam int TIME_MIN_LSB = 7;
  localparam int TIME_HOUR_LSB = 14;
  localparam int TIME_DAY_LSB = 20;
  localparam int ST_LOCK = 4;
  localparam int ST_HZ1 = 5;
  localparam int ST_ELAPSED_LSB = 8;

endpackage

//--- hw/bcd_chain.sv
// Purpose: Chain of BCD digits that counts up, wraps and can be loaded.
// Assumes: Load has priority over increment; limits are legal BCD values.
// Notes:   Carry out is combinational so a whole time chain steps in one cycle.

`timescale 1ns/1ps
`default_nettype none

module bcd_chain #(
  parameter int NDIG = 2,
  parameter logic [4*NDIG-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Control.
  input wire logic inc_i,
  input wire logic load_i,
  input wire logic [4*NDIG-1:0] load_val_i,
  input wire logic [4*NDIG-1:0] max_i,
  input wire logic [4*NDIG-1:0] min_i,
  // Result.
  output logic [4*NDIG-1:0] value_o,
  output logic carry_o
);

  logic [NDIG:0] roll;
  logic wrap;

  // A digit steps when every digit below it is at nine.
  assign roll[0] = 1'b1;
  assign wrap = (value_o == max_i);
  assign carry_o = inc_i & wrap;

  for (genvar g = 0; g < NDIG; g++) begin : g_digit
    assign roll[g+1] = roll[g] & (value_o[4*g +: 4] == bcd_time_pkg::BCD_NINE);

    // One digit register; wrap to the minimum overrides normal stepping.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        value_o[4*g +: 4] <= RST_VAL[4*g +: 4];
      end else if (load_i) begin
        value_o[4*g +: 4] <= load_val_i[4*g +: 4];
      end else if (inc_i) begin
        if (wrap) begin
          value_o[4*g +: 4] <= min_i[4*g +: 4];
        end else if (roll[g]) begin
          value_o[4*g +: 4] <= (value_o[4*g +: 4] == bcd_time_pkg::BCD_NINE) ? 4'h0 : value_o[4*g +: 4] + 4'h1;
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- hw/quality_timer.sv
// Purpose: Elapsed time since lock loss and the four time-quality lines.
// Assumes: sec_tick_i is a one-cycle pulse once per second.
// Notes:   The elapsed count saturates so the lines never fall back while unlocked.

`timescale 1ns/1ps
`default_nettype none

module quality_timer #(
  parameter logic [16:0] TH_1MS = 17'(bcd_time_pkg::Q1MS_SEC),
  parameter logic [16:0] TH_5MS = 17'(bcd_time_pkg::Q5MS_SEC),
  parameter logic [16:0] TH_50MS = 17'(bcd_time_pkg::Q50MS_SEC),
  parameter logic [16:0] TH_500MS = 17'(bcd_time_pkg::Q500MS_SEC)
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Inputs.
  input wire logic sec_tick_i,
  input wire logic locked_i,
  input wire logic display_on_i,
  // Results.
  output logic [3:0] quality_o,
  output logic [16:0] elapsed_o
);

  // Seconds since lock was lost; cleared whenever lock is present.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      elapsed_o <= '0;
    end else if (locked_i) begin
      elapsed_o <= '0;
    end else if (sec_tick_i && (elapsed_o != '1)) begin
      elapsed_o <= elapsed_o + 17'h1;
    end
  end

  // Each line is high while its error bound is exceeded; the widest also inhibits reads.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quality_o <= 4'hf;
    end else begin
      quality_o[bcd_time_pkg::QL_1MS] <= !locked_i && (elapsed_o >= TH_1MS);
      quality_o[bcd_time_pkg::QL_5MS] <= !locked_i && (elapsed_o >= TH_5MS);
      quality_o[bcd_time_pkg::QL_50MS] <= !locked_i && (elapsed_o >= TH_50MS);
      quality_o[bcd_time_pkg::QL_500MS] <= !display_on_i || (!locked_i && (elapsed_o >= TH_500MS));
    end
  end

endmodule

`default_nettype wire

//--- hw/bcd_time_out.sv
// Purpose: Parallel BCD time-of-day output with strobes and quality lines.
// Assumes: Lock arrives from the receiver as an asynchronous level.
// Notes:   Registers are reached over classic Wishbone, one aligned word each.

`timescale 1ns/1ps
`default_nettype none

module bcd_time_out #(
  parameter int MS_CYCLES = bcd_time_pkg::MS_CYCLES,
  parameter logic [16:0] TH_1MS = 17'(bcd_time_pkg::Q1MS_SEC),
  parameter logic [16:0] TH_5MS = 17'(bcd_time_pkg::Q5MS_SEC),
  parameter logic [16:0] TH_50MS = 17'(bcd_time_pkg::Q50MS_SEC),
  parameter logic [16:0] TH_500MS = 17'(bcd_time_pkg::Q500MS_SEC)
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receiver status.
  input wire logic lock_i,
  // Parallel BCD time.
  output logic [9:0] days_o,
  output logic [5:0] hours_o,
  output logic [6:0] minutes_o,
  output logic [6:0] seconds_o,
  output logic [11:0] msec_o,
  // Strobes and quality.
  output logic hz1_o,
  output logic khz_o,
  output logic [3:0] quality_o,
  // Front display flashing.
  output logic colon_blank_o,
  output logic display_blank_o
);

  // ----------------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------------
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);
  // The 1 kHz high time scales with the millisecond divider.
  localparam logic [DIV_W-1:0] KHZ_HIGH =
    DIV_W'(MS_CYCLES * bcd_time_pkg::KHZ_HIGH_US / bcd_time_pkg::MS_PERIOD_US);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic lock_meta;
  logic locked;
  logic [DIV_W-1:0] ms_div;
  logic tick_ms;
  logic [1:0] ctrl;
  logic time_load;
  logic [31:0] time_word;
  logic [31:0] next_time;
  logic [31:0] wmask;
  logic [11:0] ms_val;
  logic [7:0] sec_val;
  logic [7:0] min_val;
  logic [7:0] hour_val;
  logic [11:0] day_val;
  logic ms_carry;
  logic sec_carry;
  logic min_carry;
  logic hour_carry;
  logic [16:0] elapsed;
  logic req;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------------
  // Lock input synchroniser
  // ----------------------------------------------------------------------
  // The receiver level comes from outside this clock; only the second stage is used.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_meta <= 1'b0;
      locked <= 1'b0;
    end else begin
      lock_meta <= lock_i;
      locked <= lock_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Millisecond time base
  // ----------------------------------------------------------------------
  // A time load restarts the millisecond so a corrected time starts on a boundary.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ms_div <= '0;
    end else if (time_load || ms_div == DIV_LAST) begin
      ms_div <= '0;
    end else begin
      ms_div <= ms_div + DIV_W'(1);
    end
  end

  assign tick_ms = !time_load && (ms_div == DIV_LAST);

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
  end

  // Current counters packed as the time word seen by software.
  always_comb begin
    time_word = '0;
    time_word[bcd_time_pkg::TIME_SEC_LSB +: 7] = sec_val[6:0];
    time_word[bcd_time_pkg::TIME_MIN_LSB +: 7] = min_val[6:0];
    time_word[bcd_time_pkg::TIME_HOUR_LSB +: 6] = hour_val[5:0];
    time_word[bcd_time_pkg::TIME_DAY_LSB +: 10] = day_val[9:0];
    next_time = (time_word & ~wmask) | (wb_dat_i & wmask);
  end

  // A write to the time word is the correction step; milliseconds restart at zero.
  assign time_load = req && wb_we_i && (wb_adr_i == bcd_time_pkg::REG_TIME);

  // Control bits: display-on releases read inhibit, leap selects a 366-day year.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl <= 2'h0;
    end else if (req && wb_we_i && wb_adr_i == bcd_time_pkg::REG_CTRL && wb_sel_i[0]) begin
      ctrl <= wb_dat_i[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Time of day counters
  // ----------------------------------------------------------------------
  // Carries ripple combinationally so every digit steps on the same edge.
  bcd_chain #(.NDIG(3), .RST_VAL(12'h000)) u_ms (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .inc_i(tick_ms),
    .load_i(time_load),
    .load_val_i(12'h000),
    .max_i(bcd_time_pkg::MS_MAX),
    .min_i(12'h000),
    .value_o(ms_val),
    .carry_o(ms_carry)
  );

  bcd_chain #(.NDIG(2), .RST_VAL(8'h00)) u_sec (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .inc_i(ms_carry),
    .load_i(time_load),
    .load_val_i({1'b0, next_time[bcd_time_pkg::TIME_SEC_LSB +: 7]}),
    .max_i(bcd_time_pkg::SEC_MAX),
    .min_i(8'h00),
    .value_o(sec_val),
    .carry_o(sec_carry)
  );

  bcd_chain #(.NDIG(2), .RST_VAL(8'h00)) u_min (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .inc_i(sec_carry),
    .load_i(time_load),
    .load_val_i({1'b0, next_time[bcd_time_pkg::TIME_MIN_LSB +: 7]}),
    .max_i(bcd_time_pkg::SEC_MAX),
    .min_i(8'h00),
    .value_o(min_val),
    .carry_o(min_carry)
  );

  bcd_chain #(.NDIG(2), .RST_VAL(8'h00)) u_hour (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .inc_i(min_carry),
    .load_i(time_load),
    .load_val_i({2'b00, next_time[bcd_time_pkg::TIME_HOUR_LSB +: 6]}),
    .max_i(bcd_time_pkg::HOUR_MAX),
    .min_i(8'h00),
    .value_o(hour_val),
    .carry_o(hour_carry)
  );

  bcd_chain #(.NDIG(3), .RST_VAL(bcd_time_pkg::DAY_FIRST)) u_day (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .inc_i(hour_carry),
    .load_i(time_load),
    .load_val_i({2'b00, next_time[bcd_time_pkg::TIME_DAY_LSB +: 10]}),
    .max_i(ctrl[bcd_time_pkg::CTRL_LEAP] ? bcd_time_pkg::DAY_MAX_LEAP : bcd_time_pkg::DAY_MAX),
    .min_i(bcd_time_pkg::DAY_FIRST),
    .value_o(day_val),
    .carry_o()
  );

  // The 42 lines carry the digit registers bit for bit, high meaning one.
  assign days_o = day_val[9:0];
  assign hours_o = hour_val[5:0];
  assign minutes_o = min_val[6:0];
  assign seconds_o = sec_val[6:0];
  assign msec_o = ms_val;

  // ----------------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------------
  // 1 Hz is high for the first 900 ms of each second, 1 kHz for 100 us of each ms.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hz1_o <= 1'b0;
      khz_o <= 1'b0;
    end else begin
      hz1_o <= (ms_val[11:8] < bcd_time_pkg::HZ_LOW_DIGIT);
      khz_o <= (ms_div < KHZ_HIGH);
    end
  end

  // ----------------------------------------------------------------------
  // Quality lines
  // ----------------------------------------------------------------------
  quality_timer #(
    .TH_1MS(TH_1MS),
    .TH_5MS(TH_5MS),
    .TH_50MS(TH_50MS),
    .TH_500MS(TH_500MS)
  ) u_quality (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .sec_tick_i(ms_carry),
    .locked_i(locked),
    .display_on_i(ctrl[bcd_time_pkg::CTRL_DISP_ON]),
    .quality_o(quality_o),
    .elapsed_o(elapsed)
  );

  // Colon (50 ms line) and display (500 ms line) blank in the second half of each second while that line is high; flashing is half on, half off.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      colon_blank_o <= 1'b0;
      display_blank_o <= 1'b0;
    end else begin
      colon_blank_o <= quality_o[bcd_time_pkg::QL_50MS] && (ms_val[11:8] >= bcd_time_pkg::BCD_HALF);
      display_blank_o <= quality_o[bcd_time_pkg::QL_500MS] && (ms_val[11:8] >= bcd_time_pkg::BCD_HALF);
    end
  end

  // ----------------------------------------------------------------------
  // Register reads and acknowledge
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    unique case (wb_adr_i)
      bcd_time_pkg::REG_CTRL: next_rdata[1:0] = ctrl;
      bcd_time_pkg::REG_TIME: next_rdata = time_word;
      bcd_time_pkg::REG_MSEC: next_rdata[11:0] = ms_val;
      bcd_time_pkg::REG_STATUS: begin
        next_rdata[3:0] = quality_o;
        next_rdata[bcd_time_pkg::ST_LOCK] = locked;
        next_rdata[bcd_time_pkg::ST_HZ1] = hz1_o;
        next_rdata[bcd_time_pkg::ST_ELAPSED_LSB +: 17] = elapsed;
      end
      default: next_rdata = '0;
    endcase
  end

  // Every access, mapped or not, is acknowledged one cycle later; ack lasts one cycle.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence ms_wrap_s;
    tick_ms && (ms_val == bcd_time_pkg::MS_MAX);
  endsequence

  sequence settled_lock_s;
    (locked && ctrl[bcd_time_pkg::CTRL_DISP_ON]) [*3];
  endsequence

  ms_rollover_a: assert property (ms_wrap_s |=> (ms_val == 12'h000) && !$stable(sec_val))
    else $error("millisecond wrap did not advance seconds");
  quality_low_a: assert property (settled_lock_s |-> (quality_o == 4'h0))
    else $error("quality lines high while locked");
  quality_order_a: assert property (quality_o[bcd_time_pkg::QL_50MS] |-> quality_o[bcd_time_pkg::QL_5MS]
    && quality_o[bcd_time_pkg::QL_1MS])
    else $error("quality lines out of order");
  read_inhibit_a: assert property (!ctrl[bcd_time_pkg::CTRL_DISP_ON] [*2] |-> quality_o[bcd_time_pkg::QL_500MS])
    else $error("500 ms line low before display on");
  colon_flash_a: assert property (colon_blank_o |-> $past(quality_o[bcd_time_pkg::QL_50MS]))
    else $error("colon blanked without 50 ms line");
  display_flash_a: assert property (display_blank_o |-> $past(quality_o[bcd_time_pkg::QL_500MS]))
    else $error("display blanked without 500 ms line");
  lock_clears_a: assert property ($rose(locked) |-> ##[1:2] (quality_o[2:0] == 3'h0))
    else $error("quality lines not cleared on lock");
  elapsed_clear_a: assert property (locked |=> (elapsed == '0))
    else $error("elapsed counter not cleared under lock");
  second_stable_a: assert property (hz1_o && $past(hz1_o) && !$past(time_load) |-> $stable(sec_val))
    else $error("seconds changed while 1 Hz strobe high");
  // The divider clears on the tick edge and the strobe register follows one edge later.
  khz_rise_a: assert property (tick_ms |-> ##2 khz_o)
    else $error("1 kHz strobe not high after millisecond tick");

endmodule

`default_nettype wire

//--- tb/bcd_reader_model.sv
// Purpose: Behavioural user equipment that latches the parallel BCD time.
// Assumes: Data from seconds upward is only read while the 1 Hz line is high.
// Notes:   A high 500 ms line inhibits reading, as a careful reader would.

`timescale 1ns/1ps
`default_nettype none

module bcd_reader_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Time lines from the clock.
  input wire logic [9:0] days_i,
  input wire logic [5:0] hours_i,
  input wire logic [6:0] minutes_i,
  input wire logic [6:0] seconds_i,
  input wire logic hz1_i,
  input wire logic khz_i,
  input wire logic [3:0] quality_i,
  // High while the bench reloads the time, which may move the data.
  input wire logic skip_i,
  // Results.
  output var int latch_cnt_o,
  output var int err_cnt_o
);
  logic [29:0] held;
  logic hz1_q;
  logic khz_q;
  logic reading;
  logic prev_ok;
  int khz_n;

  // Latch on the rising 1 Hz edge, then watch that nothing moves while it stays high.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      held <= '0;
      hz1_q <= 1'b0;
      khz_q <= 1'b0;
      reading <= 1'b0;
      prev_ok <= 1'b0;
      khz_n <= 0;
      latch_cnt_o <= 0;
      err_cnt_o <= 0;
    end else begin
      hz1_q <= hz1_i;
      khz_q <= khz_i;
      if (hz1_i && !hz1_q) begin
        // A full second must hold exactly one thousand 1 kHz strobes.
        if (prev_ok && khz_n != 1000) err_cnt_o <= err_cnt_o + 1;
        khz_n <= (khz_i && !khz_q) ? 1 : 0;
        prev_ok <= !skip_i;
      end else if (khz_i && !khz_q) begin
        khz_n <= khz_n + 1;
      end
      if (skip_i) begin
        held <= {days_i, hours_i, minutes_i, seconds_i};
        prev_ok <= 1'b0;
      end else if (hz1_i && !hz1_q && !quality_i[3]) begin
        held <= {days_i, hours_i, minutes_i, seconds_i};
        latch_cnt_o <= latch_cnt_o + 1;
        reading <= 1'b1;
      end else if (!hz1_i || quality_i[3]) begin
        reading <= 1'b0;
      end else if (reading && held !== {days_i, hours_i, minutes_i, seconds_i}) begin
        err_cnt_o <= err_cnt_o + 1;
      end
    end
  end

endmodule

`default_nettype wire

//--- tb/parallel_bcd_time_output_tb_top.sv
// Purpose: Self-checking bench for the parallel BCD time output block.
// Assumes: A short millisecond and thresholds of 1 to 4 seconds keep the run brief.
// Notes:   Register traffic uses classic Wishbone single cycles.

`timescale 1ns/1ps
`default_nettype none

module parallel_bcd_time_output_tb_top;
  localparam int MSC = 10;
  localparam int SEC_CYC = MSC * 1000;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic lock_i = 1'b1;
  logic [9:0] days_o;
  logic [5:0] hours_o;
  logic [6:0] minutes_o;
  logic [6:0] seconds_o;
  logic [11:0] msec_o;
  logic hz1_o;
  logic khz_o;
  logic [3:0] quality_o;
  logic colon_blank_o;
  logic display_blank_o;
  logic skip = 1'b0;
  logic [31:0] rd;
  logic [3:0] prev_q;
  logic seen_colon = 1'b0;
  logic seen_blank = 1'b0;
  int latch_cnt;
  int model_err;
  int error_cnt = 0;
  int checks = 0;
  int cyc_cnt = 0;
  int n;

  // The 40 MHz clock.
  always #12.5 clk_i = ~clk_i;

  bcd_time_out #(.MS_CYCLES(MSC), .TH_1MS(17'h1), .TH_5MS(17'h2), .TH_50MS(17'h3), .TH_500MS(17'h4)) DUT (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .lock_i(lock_i), .days_o(days_o), .hours_o(hours_o), .minutes_o(minutes_o), .seconds_o(seconds_o),
    .msec_o(msec_o), .hz1_o(hz1_o), .khz_o(khz_o), .quality_o(quality_o), .colon_blank_o(colon_blank_o),
    .display_blank_o(display_blank_o));

  bcd_reader_model MODEL (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .days_i(days_o), .hours_i(hours_o), .minutes_i(minutes_o),
    .seconds_i(seconds_o), .hz1_i(hz1_o), .khz_i(khz_o), .quality_i(quality_o), .skip_i(skip),
    .latch_cnt_o(latch_cnt), .err_cnt_o(model_err));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle; the request holds until ack is sampled high at an edge.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 100);
    rd = wb_dat_o;
    chk("ack", 32'h1, {31'h0, wb_ack_o});
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic test_done;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hung run is cut short and counted as a mismatch.
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 90000) begin
      error_cnt++;
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // The quality register leaves its reset value only at the first edge after release.
    repeat (2) @(negedge clk_i);
    chk("days", 32'h001, {22'h0, days_o});
    chk("quality", 32'h8, {28'h0, quality_o});
    wb(1'b1, bcd_time_pkg::REG_CTRL, 32'h1);
    wb(1'b0, bcd_time_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    repeat (4) @(negedge clk_i);
    chk("quality", 32'h0, {28'h0, quality_o});
    $display("test reset and display on done");
    // Last second of a common year rolls over to day one.
    skip <= 1'b1;
    wb(1'b1, bcd_time_pkg::REG_TIME, {2'h0, 10'h365, 6'h23, 7'h59, 7'h59});
    skip <= 1'b0;
    n = 0;
    while (seconds_o === 7'h59 && n < 12000) begin
      @(negedge clk_i);
      n++;
    end
    chk("rollover", {2'h0, 10'h001, 6'h00, 7'h00, 7'h00}, {2'h0, days_o, hours_o, minutes_o, seconds_o});
    chk("msec", 32'h0, {20'h0, msec_o});
    wb(1'b0, bcd_time_pkg::REG_TIME, 32'h0);
    chk("time read", {2'h0, 10'h001, 6'h00, 7'h00, 7'h00}, rd);
    // In a leap year day 365 steps on to 366 instead of wrapping.
    wb(1'b1, bcd_time_pkg::REG_CTRL, 32'h3);
    skip <= 1'b1;
    wb(1'b1, bcd_time_pkg::REG_TIME, {2'h0, 10'h365, 6'h23, 7'h59, 7'h59});
    skip <= 1'b0;
    n = 0;
    while (seconds_o === 7'h59 && n < 12000) begin
      @(negedge clk_i);
      n++;
    end
    chk("leap day", {22'h0, 10'h366}, {22'h0, days_o});
    wb(1'b1, bcd_time_pkg::REG_CTRL, 32'h1);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test rollover done");
    // Lock loss raises the lines one at a time.
    @(posedge clk_i);
    lock_i <= 1'b0;
    prev_q = 4'h0;
    n = 0;
    while (quality_o !== 4'hf && n < 6 * SEC_CYC) begin
      @(negedge clk_i);
      n++;
      seen_colon |= colon_blank_o;
      if (quality_o !== prev_q) begin
        chk("quality step", {28'h0, prev_q[2:0], 1'b1}, {28'h0, quality_o});
        prev_q = quality_o;
      end
    end
    chk("q500 time", 32'h1, {31'h0, n >= 3 * SEC_CYC && n <= 4 * SEC_CYC + 20});
    repeat (SEC_CYC) begin
      @(negedge clk_i);
      seen_blank |= display_blank_o;
    end
    chk("colon flash", 32'h1, {31'h0, seen_colon});
    chk("display flash", 32'h1, {31'h0, seen_blank});
    chk("quality held", 32'hf, {28'h0, quality_o});
    @(posedge clk_i);
    lock_i <= 1'b1;
    repeat (6) @(negedge clk_i);
    chk("quality relock", 32'h0, {28'h0, quality_o});
    wb(1'b0, bcd_time_pkg::REG_STATUS, 32'h0);
    chk("elapsed", 32'h10, rd & 32'h01ff_ff1f);
    $display("test lock loss done");
    // Display off forces the read inhibit.
    wb(1'b1, bcd_time_pkg::REG_CTRL, 32'h0);
    repeat (2) @(negedge clk_i);
    chk("quality", 32'h8, {28'h0, quality_o});
    chk("reader latches", 32'h1, {31'h0, latch_cnt > 0});
    chk("reader errors", 32'h0, 32'(model_err));
    $display("test display off done");
    test_done();
  end

endmodule

`default_nettype wire
